//--- hw/pmsr_pkg.sv
// package: register map, fields and carriers for the phy management status slice
package pmsr_pkg;
    localparam logic [4:0] PMSR_OFS_MMD_CTRL = 5'h0d;
    localparam logic [4:0] PMSR_OFS_MMD_WINDOW = 5'h0e;
    localparam logic [4:0] PMSR_OFS_EXT_CAP = 5'h0f;
    localparam logic [4:0] PMSR_OFS_LINK_PERF = 5'h10;
    localparam logic [15:0] PMSR_RST_WINDOW = 16'h0000;
    localparam logic [15:0] PMSR_RST_EXT_CAP = 16'h3000;
    localparam logic [15:0] PMSR_RST_LINK_PERF = 16'h80ff;
    localparam logic [7:0] PMSR_PPM_INVALID = 8'h80;
    localparam logic [3:0] PMSR_SNR_INVALID = 4'hf;
    localparam logic [3:0] PMSR_SNR_MAX = 4'he;
    localparam logic [3:0] PMSR_LEN_INVALID = 4'hf;
    localparam logic [1:0] PMSR_ACT_ADDRESS = 2'h0;
    localparam logic [1:0] PMSR_ACT_DATA = 2'h1;
    localparam logic [1:0] PMSR_ACT_DATA_PI = 2'h2;
    localparam logic [1:0] PMSR_ACT_DATA_PIWR = 2'h3;

    // management register access request
    typedef struct packed {
        logic req;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pmsr_req_t;

    // access to the selected mmd
    typedef struct packed {
        logic req;
        logic wr;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pmsr_mmd_t;

    // link measurements from the receiver
    typedef struct packed {
        logic link_up;
        logic ppm_valid;
        logic [7:0] ppm;
        logic snr_valid;
        logic [4:0] snr_db;
        logic len_valid;
        logic [4:0] len_10m;
    } pmsr_meas_t;
endpackage

//--- hw/pmsr_perf_fmt.sv
// module: formats link measurements into the link performance word
`timescale 1ns/1ps
module pmsr_perf_fmt
    import pmsr_pkg::*;
(
    // measurements
    input wire pmsr_meas_t meas,
    // formatted word
    output logic [15:0] perf
);
    wire [7:0] ppm_f;
    wire [3:0] snr_f;
    wire [3:0] len_f;

    assign ppm_f = (meas.link_up && meas.ppm_valid && meas.ppm != PMSR_PPM_INVALID)
        ? meas.ppm : PMSR_PPM_INVALID;
    assign snr_f = !(meas.link_up && meas.snr_valid) ? PMSR_SNR_INVALID
        : (meas.snr_db > 5'(PMSR_SNR_MAX)) ? PMSR_SNR_MAX : meas.snr_db[3:0];
    assign len_f = !(meas.link_up && meas.len_valid) ? PMSR_LEN_INVALID
        : (meas.len_10m >= 5'(PMSR_LEN_INVALID)) ? PMSR_LEN_INVALID - 4'h1
        : meas.len_10m[3:0];
    assign perf = {ppm_f, snr_f, len_f};
endmodule

//--- hw/pmsr_regs.sv
// module: mmd window, extended capability and link performance registers
`timescale 1ns/1ps
// Notes on behaviour
// - window goes to mmd address or data
// - access type 00 address, 01 data, 10 increments, 11 increments on writes
// - device field picks the target mmd
// - capability register read-only, reset 3000 hex
// - bits 15..12 report gigabit duplex capabilities
// - upper byte signed ppm, 0x80 invalid
// - snr margin bits 7..4, saturates, 1111 invalid
// - low nibble length in 10 m, 15 invalid
module pmsr_regs
    import pmsr_pkg::*;
#(
    parameter logic [3:0] CAP_FLAGS = PMSR_RST_EXT_CAP[15:12]
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // management access, one-cycle request
    input wire pmsr_req_t mreq,
    output logic [15:0] mrdata,
    output logic mack,
    // control register fields from the mmd control register
    input wire logic [1:0] access_type_field,
    input wire logic [4:0] mmd_select_field,
    // mmd side
    output pmsr_mmd_t mmd,
    input wire logic [15:0] mmd_rdata,
    // link measurements
    input wire pmsr_meas_t meas
);
    localparam int NUM_MMD = 2 ** $bits(mmd_select_field);
    logic [15:0] mmd_addr_q [NUM_MMD];
    logic [15:0] perf_q;
    logic [15:0] perf_w;
    logic [15:0] rdata_d;
    logic [15:0] mrdata_q;
    logic mack_q;
    pmsr_mmd_t mmd_q;

    // request aimed at one register offset
    function automatic logic f_sel(input pmsr_req_t r, input logic [4:0] ofs);
        return r.req && r.addr == ofs;
    endfunction

    wire hit_win = f_sel(mreq, PMSR_OFS_MMD_WINDOW);
    wire rd_cap = f_sel(mreq, PMSR_OFS_EXT_CAP) && !mreq.wr;
    wire rd_perf = f_sel(mreq, PMSR_OFS_LINK_PERF) && !mreq.wr;
    wire wr_perf = f_sel(mreq, PMSR_OFS_LINK_PERF) && mreq.wr;
    wire rd_any = mreq.req && !mreq.wr;
    wire is_addr = access_type_field == PMSR_ACT_ADDRESS;
    wire [15:0] cur_addr = mmd_addr_q[mmd_select_field];
    wire do_inc = !is_addr && (access_type_field == PMSR_ACT_DATA_PI
        || (access_type_field == PMSR_ACT_DATA_PIWR && mreq.wr));
    wire [15:0] cap_word = {CAP_FLAGS, 12'h000};
    wire data_acc = hit_win && !is_addr;

    pmsr_perf_fmt u_fmt (
        .meas(meas),
        .perf(perf_w)
    );

    always_comb begin
        case (mreq.addr)
            PMSR_OFS_MMD_WINDOW: rdata_d = is_addr ? cur_addr : mmd_rdata;
            PMSR_OFS_EXT_CAP: rdata_d = cap_word;
            PMSR_OFS_LINK_PERF: rdata_d = perf_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_MMD; i++) begin
                mmd_addr_q[i] <= PMSR_RST_WINDOW;
            end
        end else if (hit_win && is_addr && mreq.wr) begin
            mmd_addr_q[mmd_select_field] <= mreq.wdata;
        end else if (hit_win && do_inc) begin
            mmd_addr_q[mmd_select_field] <= cur_addr + 16'h0001;
        end
    end

    // measurement word only follows the receiver; bus writes never reach it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            perf_q <= PMSR_RST_LINK_PERF;
        end else begin
            perf_q <= perf_w;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mrdata_q <= 16'h0000;
            mack_q <= 1'b0;
            mmd_q <= '0;
        end else begin
            mack_q <= mreq.req;
            mrdata_q <= rd_any ? rdata_d : mrdata_q;
            mmd_q.req <= data_acc;
            mmd_q.wr <= data_acc && mreq.wr;
            mmd_q.dev <= mmd_select_field;
            mmd_q.addr <= cur_addr;
            mmd_q.wdata <= mreq.wdata;
        end
    end

    assign mrdata = mrdata_q;
    assign mack = mack_q;
    assign mmd = mmd_q;

    // steps of a window access and of its answer
    sequence s_addr_wr;
        hit_win && is_addr && mreq.wr;
    endsequence
    sequence s_data_acc;
        data_acc;
    endsequence
    sequence s_ack_next;
        ##1 mack;
    endsequence

    a_cap_readonly: assert property (@(posedge clk) disable iff (!rstn)
        rd_cap |=> mrdata == {CAP_FLAGS, 12'h000} && mack)
        else $error("capability read wrong");
    a_cap_reserved: assert property (@(posedge clk) disable iff (!rstn)
        rd_cap |=> mrdata[11:0] == 12'h000)
        else $error("reserved capability bits set");

    a_win_addr_wr: assert property (@(posedge clk) disable iff (!rstn)
        s_addr_wr |=> mmd_addr_q[$past(mmd_select_field)] == $past(mreq.wdata) && !mmd.req)
        else $error("address write lost");
    a_win_addr_rd: assert property (@(posedge clk) disable iff (!rstn)
        hit_win && is_addr && !mreq.wr |=> mrdata == $past(cur_addr))
        else $error("address read wrong");
    a_win_data_fwd: assert property (@(posedge clk) disable iff (!rstn)
        s_data_acc |=> mmd.req && mmd.addr == $past(cur_addr))
        else $error("data access not forwarded");
    a_win_data_rd: assert property (@(posedge clk) disable iff (!rstn)
        data_acc && !mreq.wr |=> mrdata == $past(mmd_rdata))
        else $error("data read not returned");
    a_mmd_wr_qual: assert property (@(posedge clk) disable iff (!rstn)
        data_acc && mreq.wr |=> mmd.wr && mmd.wdata == $past(mreq.wdata))
        else $error("data write not forwarded");
    a_mmd_rd_qual: assert property (@(posedge clk) disable iff (!rstn)
        data_acc && !mreq.wr |=> !mmd.wr)
        else $error("data read forwarded as write");
    a_mmd_req_idle: assert property (@(posedge clk) disable iff (!rstn)
        !data_acc |=> !mmd.req)
        else $error("mmd request without data access");

    a_inc_piwr_rd: assert property (@(posedge clk) disable iff (!rstn)
        hit_win && !mreq.wr && access_type_field == PMSR_ACT_DATA_PIWR
        |=> mmd_addr_q[$past(mmd_select_field)] == $past(cur_addr))
        else $error("read incremented in write-only mode");
    a_inc_pi: assert property (@(posedge clk) disable iff (!rstn)
        hit_win && access_type_field == PMSR_ACT_DATA_PI
        |=> mmd_addr_q[$past(mmd_select_field)] == $past(cur_addr) + 16'h0001)
        else $error("post increment missed");
    a_inc_piwr_wr: assert property (@(posedge clk) disable iff (!rstn)
        hit_win && mreq.wr && access_type_field == PMSR_ACT_DATA_PIWR
        |=> mmd_addr_q[$past(mmd_select_field)] == $past(cur_addr) + 16'h0001)
        else $error("write increment missed");
    a_data_noinc: assert property (@(posedge clk) disable iff (!rstn)
        hit_win && access_type_field == PMSR_ACT_DATA
        |=> mmd_addr_q[$past(mmd_select_field)] == $past(cur_addr))
        else $error("plain data access moved the address");
    a_dev_select: assert property (@(posedge clk) disable iff (!rstn)
        data_acc |=> mmd.dev == $past(mmd_select_field))
        else $error("wrong mmd selected");

    a_ack_every: assert property (@(posedge clk) disable iff (!rstn)
        mreq.req |-> s_ack_next)
        else $error("access not acknowledged");
    a_ack_idle: assert property (@(posedge clk) disable iff (!rstn)
        !mreq.req |=> !mack)
        else $error("acknowledge without access");
    a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
        !rd_any |=> $stable(mrdata))
        else $error("read data changed without read");

    a_ppm_invalid: assert property (@(posedge clk) disable iff (!rstn)
        !meas.link_up |=> perf_q[15:8] == PMSR_PPM_INVALID)
        else $error("ppm not invalid with link down");
    a_ppm_pass: assert property (@(posedge clk) disable iff (!rstn)
        meas.link_up && meas.ppm_valid |=> perf_q[15:8] == $past(meas.ppm))
        else $error("ppm not reported");
    a_snr_range: assert property (@(posedge clk) disable iff (!rstn)
        meas.link_up && meas.snr_valid |=> perf_q[7:4] != PMSR_SNR_INVALID)
        else $error("valid snr reported as invalid");
    a_snr_sat: assert property (@(posedge clk) disable iff (!rstn)
        meas.link_up && meas.snr_valid && meas.snr_db > 5'(PMSR_SNR_MAX)
        |=> perf_q[7:4] == PMSR_SNR_MAX)
        else $error("snr not saturated");
    a_snr_invalid: assert property (@(posedge clk) disable iff (!rstn)
        !(meas.link_up && meas.snr_valid) |=> perf_q[7:4] == PMSR_SNR_INVALID)
        else $error("snr not invalid");
    a_len_invalid: assert property (@(posedge clk) disable iff (!rstn)
        !(meas.link_up && meas.len_valid) |=> perf_q[3:0] == PMSR_LEN_INVALID)
        else $error("length not invalid");
    a_len_clamp: assert property (@(posedge clk) disable iff (!rstn)
        meas.link_up && meas.len_valid |=> perf_q[3:0] != PMSR_LEN_INVALID)
        else $error("valid length reported as invalid");

    a_perf_read: assert property (@(posedge clk) disable iff (!rstn)
        rd_perf |=> mrdata == $past(perf_q))
        else $error("performance read wrong");
    a_perf_nowrite: assert property (@(posedge clk) disable iff (!rstn)
        wr_perf |=> perf_q == $past(perf_w))
        else $error("write reached performance word");
endmodule

//--- tb/pmsr_mmd_model.sv
// far side model: one data word per mmd device
`timescale 1ns/1ps
module pmsr_mmd_model
    import pmsr_pkg::*;
(
    // clock
    input wire logic clk,
    // mmd access and select
    input wire pmsr_mmd_t mmd,
    input wire logic [4:0] dev_sel,
    output logic [15:0] rdata
);
    logic [15:0] mem [32] = '{default: 16'h0};
    always @(posedge clk) if (mmd.req && mmd.wr) mem[mmd.dev] <= mmd.wdata;
    assign rdata = mem[dev_sel];
endmodule

//--- tb/phy_mgmt_status_regs_tb.sv
// bench for the management status registers
`timescale 1ns/1ps
module phy_mgmt_status_regs_tb;
    import pmsr_pkg::*;
    logic clk = 0;
    logic rstn = 0;
    pmsr_req_t mreq = '0;
    logic [15:0] mrdata, mmd_rdata, rd;
    logic mack;
    logic [1:0] act = 2'h0;
    logic [4:0] sel = 5'h0;
    pmsr_mmd_t mmd, mq;
    pmsr_meas_t meas = '0;
    int mismatches = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    pmsr_regs dut (.clk(clk), .rstn(rstn), .mreq(mreq), .mrdata(mrdata), .mack(mack),
        .access_type_field(act), .mmd_select_field(sel), .mmd(mmd),
        .mmd_rdata(mmd_rdata), .meas(meas));
    pmsr_mmd_model far (.clk(clk), .mmd(mmd), .dev_sel(sel), .rdata(mmd_rdata));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        mreq = '{req: 1'b1, wr: w, addr: a, wdata: d};
        @(posedge clk);
        #1;
        mreq = '0;
        rd = mrdata;
        mq = mmd;
        chk({15'h0, mack}, 16'h1, "ack");
        @(posedge clk);
        #1;
    endtask
    task automatic mm(input logic [1:0] t, input logic w, input logic [15:0] ea);
        act = t;
        acc(w, PMSR_OFS_MMD_WINDOW, 16'hbeef);
        chk({15'h0, mq.req}, 16'h1, "mmd req");
        chk(mq.addr, ea, "mmd addr");
        chk({11'h0, mq.dev}, {11'h0, sel}, "mmd dev");
        chk({15'h0, mq.wr}, {15'h0, w}, "mmd wr");
        chk(mq.wdata, 16'hbeef, "mmd wdata");
    endtask
    task automatic t_reset;
        acc(0, PMSR_OFS_EXT_CAP, 16'h0);
        chk(rd, 16'h3000, "cap");
        chk(rd & 16'hf000, 16'h3000, "cap flags");
        acc(0, PMSR_OFS_LINK_PERF, 16'h0);
        chk(rd, 16'h80ff, "perf");
        acc(0, PMSR_OFS_MMD_WINDOW, 16'h0);
        chk(rd, 16'h0000, "window");
        $display("test reset done");
    endtask
    task automatic t_ro;
        acc(1, PMSR_OFS_EXT_CAP, 16'hffff);
        acc(0, PMSR_OFS_EXT_CAP, 16'h0);
        chk(rd, 16'h3000, "cap write");
        acc(1, PMSR_OFS_LINK_PERF, 16'h1234);
        acc(0, PMSR_OFS_LINK_PERF, 16'h0);
        chk(rd, 16'h80ff, "perf write");
        $display("test read only done");
    endtask
    task automatic t_mmd;
        sel = 5'h05;
        act = 2'h0;
        acc(1, PMSR_OFS_MMD_WINDOW, 16'h0123);
        chk({15'h0, mq.req}, 16'h0, "addr mode req");
        mm(2'h2, 0, 16'h0123);
        mm(2'h2, 0, 16'h0124);
        mm(2'h1, 1, 16'h0125);
        mm(2'h1, 0, 16'h0125);
        chk(rd, 16'hbeef, "data read");
        mm(2'h3, 0, 16'h0125);
        mm(2'h3, 1, 16'h0125);
        mm(2'h1, 0, 16'h0126);
        sel = 5'h09;
        act = 2'h0;
        acc(0, PMSR_OFS_MMD_WINDOW, 16'h0);
        chk(rd, 16'h0000, "other mmd");
        $display("test mmd window done");
    endtask
    task automatic t_perf;
        pmsr_meas_t m [5];
        logic [15:0] e [5];
        m = '{'{1, 1, 8'hfb, 1, 5'd9, 1, 5'd3}, '{1, 1, 8'h05, 1, 5'd20, 1, 5'd15},
            '{1, 0, 8'h05, 0, 5'd3, 0, 5'd3}, '{1, 1, 8'h80, 1, 5'd0, 1, 5'd0},
            '{0, 1, 8'h05, 1, 5'd3, 1, 5'd3}};
        e = '{16'hfb93, 16'h05ee, 16'h80ff, 16'h8000, 16'h80ff};
        for (int i = 0; i < 5; i++) begin
            meas = m[i];
            @(posedge clk);
            #1;
            acc(0, PMSR_OFS_LINK_PERF, 16'h0);
            chk(rd, e[i], "perf word");
        end
        $display("test performance done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rstn = 1;
        t_reset;
        t_ro;
        t_mmd;
        t_perf;
        final_report;
    end
    initial begin
        #400000;
        mismatches++;
        final_report;
    end
endmodule
